// File: ppfm_cfg.svh
`ifndef PPFM_CFG_SVH
`define PPFM_CFG_SVH
// Register byte offsets
`define PPFM_ADDR_P2_DIR 8'h00
`define PPFM_ADDR_P2_SEL 8'h04
`define PPFM_ADDR_ANALOG_PAD_DISABLE 8'h08
`define PPFM_ADDR_CASEL 8'h0C
`define PPFM_ADDR_P3_DIR 8'h10
`define PPFM_ADDR_P3_SEL 8'h14
`define PPFM_ADDR_P4_DIR 8'h18
`define PPFM_ADDR_P4_SEL 8'h1C
`define PPFM_ADDR_P2_OUT 8'h20
`define PPFM_ADDR_P3_OUT 8'h24
`define PPFM_ADDR_P4_OUT 8'h28
`define PPFM_ADDR_P2_IN 8'h2C
`define PPFM_ADDR_P3_IN 8'h30
`define PPFM_ADDR_P4_IN 8'h34
// Port 2 fields sit in bits 7:6, port 3 function select in bits 5:0
`define PPFM_P2_LSB 6
`define PPFM_P2_MSB 7
`define PPFM_P3_SEL_MSB 5
// Reset values
`define PPFM_RST_P2_DIR 2'b11
`define PPFM_RST_P2_SEL 2'b11
`define PPFM_RST_2B 2'b00
`define PPFM_RST_P3_SEL 6'h00
`define PPFM_RST_8B 8'h00
`endif

// File: ppfm_pkg.sv
package ppfm_pkg;
	typedef enum logic [1:0] {
		PPFM_P2_GPIO = 2'b00,
		PPFM_P2_ANALOG = 2'b01,
		PPFM_P2_XTAL = 2'b10,
		PPFM_P2_IDLE = 2'b11
	} ppfm_p2_mode_t;
	typedef logic [7:0] ppfm_byte_t;
endpackage

// File: ppfm_port_mux.sv
`timescale 1ns/1ps
`include "ppfm_cfg.svh"
module ppfm_port_mux (
	input wire logic pclk, // Core clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [1:0] p2_pad_in, // P2.7:6 pad level
	output logic [1:0] p2_pad_out, // P2.7:6 pad drive value
	output logic [1:0] p2_pad_oe_n, // P2.7:6 enable, low drives
	input wire logic [7:0] p3_pad_in, // Port 3 pad level
	output logic [7:0] p3_pad_out, // Port 3 drive value
	output logic [7:0] p3_pad_oe_n, // Port 3 enable, low drives
	input wire logic [7:0] p4_pad_in, // Port 4 pad level
	output logic [7:0] p4_pad_out, // Port 4 drive value
	output logic [7:0] p4_pad_oe_n, // Port 4 enable, low drives
	output logic crystal_input_en, // P2.6 routed to oscillator
	output logic crystal_output_en, // P2.7 routed to oscillator
	output logic comparator_channel_six_en, // P2.6 to comparator
	output logic comparator_channel_seven_en, // P2.7 to comparator
	input wire logic [5:0] serial_out, // Serial module drive, P3.5:0
	input wire logic [5:0] serial_oe, // Serial module direction, 1 drives
	input wire logic serial_i2c_mode, // Serial module in I2C mode
	output logic [5:0] serial_in, // Pad level to serial module
	input wire logic [2:0] timer_b_out, // Timer outputs 2:0
	input wire logic aux_clock, // Auxiliary clock to P4.6
	output logic capture_input_0a, // From P4.0
	output logic capture_input_1a, // From P4.1
	output logic capture_input_2a, // From P4.2
	output logic capture_input_0b, // From P4.3
	output logic capture_input_1b, // From P4.4
	output logic timer_b_output_hiz_control, // From P4.6
	output logic timer_b_external_clock // From P4.7
);
	logic [1:0] port2_direction_r;
	logic [1:0] port2_function_select_r;
	logic [1:0] analog_pad_disable_r;
	logic [1:0] comparator_input_select_r;
	logic [1:0] port2_output_r;
	logic [7:0] port3_direction_r;
	logic [5:0] port3_function_select_r;
	logic [7:0] port3_output_r;
	logic [7:0] port4_direction_r;
	logic [7:0] port4_function_select_r;
	logic [7:0] port4_output_r;
	logic [17:0] pad_meta_r;
	logic [17:0] pad_sync_r;
	logic [1:0] p2_sync;
	logic [7:0] p3_sync;
	logic [7:0] p4_sync;
	logic setup;
	logic access;
	logic hit;
	logic [31:0] rd_nxt;
	logic [1:0] p2_out_nxt;
	logic [1:0] p2_oe_nxt;
	logic [1:0] p2_in_en;
	logic [1:0] xtal_nxt;
	logic [1:0] comp_nxt;
	logic [7:0] p3_out_nxt;
	logic [7:0] p3_oe_nxt;
	logic [5:0] serial_in_nxt;
	logic [7:0] p4_out_nxt;
	logic [7:0] p4_oe_nxt;
	logic [7:0] p4_cap_nxt;
	ppfm_pkg::ppfm_p2_mode_t p2_mode [2];

	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign p2_sync = pad_sync_r[1:0];
	assign p3_sync = pad_sync_r[9:2];
	assign p4_sync = pad_sync_r[17:10];

	// Pad inputs come from outside the clock domain
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_meta_r <= 18'h0_0000;
			pad_sync_r <= 18'h0_0000;
		end
		else
		begin
			pad_meta_r <= {p4_pad_in, p3_pad_in, p2_pad_in};
			pad_sync_r <= pad_meta_r;
		end
	end

	// Address decode and read mux
	always_comb
	begin
		hit = 1'b1;
		rd_nxt = 32'h0000_0000;
		case (paddr)
			`PPFM_ADDR_P2_DIR: rd_nxt[`PPFM_P2_MSB:`PPFM_P2_LSB] = port2_direction_r;
			`PPFM_ADDR_P2_SEL: rd_nxt[`PPFM_P2_MSB:`PPFM_P2_LSB] = port2_function_select_r;
			`PPFM_ADDR_ANALOG_PAD_DISABLE: rd_nxt[`PPFM_P2_MSB:`PPFM_P2_LSB] = analog_pad_disable_r;
			`PPFM_ADDR_CASEL: rd_nxt[`PPFM_P2_MSB:`PPFM_P2_LSB] = comparator_input_select_r;
			`PPFM_ADDR_P2_OUT: rd_nxt[`PPFM_P2_MSB:`PPFM_P2_LSB] = port2_output_r;
			`PPFM_ADDR_P2_IN: rd_nxt[`PPFM_P2_MSB:`PPFM_P2_LSB] = p2_sync & p2_in_en;
			`PPFM_ADDR_P3_DIR: rd_nxt[7:0] = port3_direction_r;
			`PPFM_ADDR_P3_SEL: rd_nxt[`PPFM_P3_SEL_MSB:0] = port3_function_select_r;
			`PPFM_ADDR_P3_OUT: rd_nxt[7:0] = port3_output_r;
			`PPFM_ADDR_P3_IN: rd_nxt[7:0] = p3_sync;
			`PPFM_ADDR_P4_DIR: rd_nxt[7:0] = port4_direction_r;
			`PPFM_ADDR_P4_SEL: rd_nxt[7:0] = port4_function_select_r;
			`PPFM_ADDR_P4_OUT: rd_nxt[7:0] = port4_output_r;
			`PPFM_ADDR_P4_IN: rd_nxt[7:0] = p4_sync;
			default: hit = 1'b0;
		endcase
	end

	// APB answer: zero wait states, error on unmapped address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~hit;
			if (setup)
			begin
				prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
			end
		end
	end

	// Port 2 and comparator control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port2_direction_r <= `PPFM_RST_P2_DIR;
			port2_function_select_r <= `PPFM_RST_P2_SEL;
			analog_pad_disable_r <= `PPFM_RST_2B;
			comparator_input_select_r <= `PPFM_RST_2B;
			port2_output_r <= `PPFM_RST_2B;
		end
		else if (access && pwrite)
		begin
			case (paddr)
				`PPFM_ADDR_P2_DIR: port2_direction_r <= pwdata[`PPFM_P2_MSB:`PPFM_P2_LSB];
				`PPFM_ADDR_P2_SEL: port2_function_select_r <= pwdata[`PPFM_P2_MSB:`PPFM_P2_LSB];
				`PPFM_ADDR_ANALOG_PAD_DISABLE: analog_pad_disable_r <= pwdata[`PPFM_P2_MSB:`PPFM_P2_LSB];
				`PPFM_ADDR_CASEL: comparator_input_select_r <= pwdata[`PPFM_P2_MSB:`PPFM_P2_LSB];
				`PPFM_ADDR_P2_OUT: port2_output_r <= pwdata[`PPFM_P2_MSB:`PPFM_P2_LSB];
				default: ;
			endcase
		end
	end

	// Port 3 and port 4 control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port3_direction_r <= `PPFM_RST_8B;
			port3_function_select_r <= `PPFM_RST_P3_SEL;
			port3_output_r <= `PPFM_RST_8B;
			port4_direction_r <= `PPFM_RST_8B;
			port4_function_select_r <= `PPFM_RST_8B;
			port4_output_r <= `PPFM_RST_8B;
		end
		else if (access && pwrite)
		begin
			case (paddr)
				`PPFM_ADDR_P3_DIR: port3_direction_r <= pwdata[7:0];
				`PPFM_ADDR_P3_SEL: port3_function_select_r <= pwdata[`PPFM_P3_SEL_MSB:0];
				`PPFM_ADDR_P3_OUT: port3_output_r <= pwdata[7:0];
				`PPFM_ADDR_P4_DIR: port4_direction_r <= pwdata[7:0];
				`PPFM_ADDR_P4_SEL: port4_function_select_r <= pwdata[7:0];
				`PPFM_ADDR_P4_OUT: port4_output_r <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Port 2 pads: GPIO, crystal or comparator
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (port2_function_select_r[i])
			begin
				p2_mode[i] = port2_direction_r[i] ? ppfm_pkg::PPFM_P2_XTAL : ppfm_pkg::PPFM_P2_IDLE;
			end
			else
			begin
				p2_mode[i] = analog_pad_disable_r[i] ? ppfm_pkg::PPFM_P2_ANALOG : ppfm_pkg::PPFM_P2_GPIO;
			end
			p2_out_nxt[i] = 1'b0;
			p2_oe_nxt[i] = 1'b0;
			case (p2_mode[i])
				ppfm_pkg::PPFM_P2_GPIO:
				begin
					p2_out_nxt[i] = port2_output_r[i];
					p2_oe_nxt[i] = port2_direction_r[i];
				end
				default:
				begin
					p2_out_nxt[i] = 1'b0;
					p2_oe_nxt[i] = 1'b0;
				end
			endcase
			p2_in_en[i] = (p2_mode[i] == ppfm_pkg::PPFM_P2_GPIO) & ~comparator_input_select_r[i];
			xtal_nxt[i] = (p2_mode[i] == ppfm_pkg::PPFM_P2_XTAL);
			comp_nxt[i] = (p2_mode[i] == ppfm_pkg::PPFM_P2_ANALOG) | comparator_input_select_r[i];
		end
	end

	// Port 3 pads: GPIO or serial
	always_comb
	begin
		serial_in_nxt = 6'h00;
		p3_out_nxt = port3_output_r;
		p3_oe_nxt = port3_direction_r;
		// Only pins 5:0 have a serial function; 7:6 stay GPIO
		for (int i = 0; i < 6; i++)
		begin
			if (port3_function_select_r[i])
			begin
				serial_in_nxt[i] = p3_sync[i];
				if (serial_i2c_mode && (i == 1 || i == 2))
				begin
					p3_out_nxt[i] = 1'b0;
					p3_oe_nxt[i] = serial_oe[i] & ~serial_out[i];
				end
				else
				begin
					p3_out_nxt[i] = serial_out[i];
					p3_oe_nxt[i] = serial_oe[i];
				end
			end
		end
	end

	// Port 4 pads: GPIO or timer
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			p4_out_nxt[i] = port4_output_r[i];
			p4_oe_nxt[i] = port4_direction_r[i];
			p4_cap_nxt[i] = port4_function_select_r[i] & ~port4_direction_r[i] & p4_sync[i];
			if (port4_function_select_r[i])
			begin
				p4_oe_nxt[i] = port4_direction_r[i] & (i != 7);
				case (i)
					0, 3: p4_out_nxt[i] = timer_b_out[0];
					1, 4: p4_out_nxt[i] = timer_b_out[1];
					2, 5: p4_out_nxt[i] = timer_b_out[2];
					6: p4_out_nxt[i] = aux_clock;
					default: p4_out_nxt[i] = 1'b0;
				endcase
			end
		end
	end

	// Registered pad drive
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			p2_pad_out <= 2'b00;
			p2_pad_oe_n <= 2'b11;
			p3_pad_out <= 8'h00;
			p3_pad_oe_n <= 8'hFF;
			p4_pad_out <= 8'h00;
			p4_pad_oe_n <= 8'hFF;
		end
		else
		begin
			p2_pad_out <= p2_out_nxt;
			p2_pad_oe_n <= ~p2_oe_nxt;
			p3_pad_out <= p3_out_nxt;
			p3_pad_oe_n <= ~p3_oe_nxt;
			p4_pad_out <= p4_out_nxt;
			p4_pad_oe_n <= ~p4_oe_nxt;
		end
	end

	// Registered peripheral routing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crystal_input_en <= 1'b1;
			crystal_output_en <= 1'b1;
			comparator_channel_six_en <= 1'b0;
			comparator_channel_seven_en <= 1'b0;
			serial_in <= 6'h00;
			capture_input_0a <= 1'b0;
			capture_input_1a <= 1'b0;
			capture_input_2a <= 1'b0;
			capture_input_0b <= 1'b0;
			capture_input_1b <= 1'b0;
			timer_b_output_hiz_control <= 1'b0;
			timer_b_external_clock <= 1'b0;
		end
		else
		begin
			crystal_input_en <= xtal_nxt[0];
			crystal_output_en <= xtal_nxt[1];
			comparator_channel_six_en <= comp_nxt[0];
			comparator_channel_seven_en <= comp_nxt[1];
			serial_in <= serial_in_nxt;
			capture_input_0a <= p4_cap_nxt[0];
			capture_input_1a <= p4_cap_nxt[1];
			capture_input_2a <= p4_cap_nxt[2];
			capture_input_0b <= p4_cap_nxt[3];
			capture_input_1b <= p4_cap_nxt[4];
			timer_b_output_hiz_control <= p4_cap_nxt[6];
			timer_b_external_clock <= p4_cap_nxt[7];
		end
	end
endmodule

// File: ppfm_port_mux_properties.sv
`timescale 1ns/1ps
module ppfm_port_mux_props (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pready, // Ready
	input wire logic [1:0] p2_pad_oe_n, // P2 enable
	input wire logic crystal_input_en, // Crystal in
	input wire logic [7:0] p3_pad_out, // P3 drive
	input wire logic [7:0] p3_pad_oe_n, // P3 enable
	input wire logic [7:0] p4_pad_oe_n, // P4 enable
	input wire logic [5:0] serial_out, // Serial drive
	input wire logic [5:0] serial_oe, // Serial direction
	input wire logic serial_i2c_mode, // I2C flag
	input wire logic [5:0] serial_in, // To serial
	input wire logic capture_input_0a, // From P4.0
	input wire logic timer_b_output_hiz_control, // From P4.6
	input wire logic timer_b_external_clock // From P4.7
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_READY: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not one cycle after setup");
	AST_XTAL_NODRIVE: assert property (crystal_input_en |-> p2_pad_oe_n[0])
		else $error("crystal pad driven");
	AST_CAP_INPUT: assert property (capture_input_0a |-> p4_pad_oe_n[0])
		else $error("capture pin driven");
	AST_HIZ_INPUT: assert property (timer_b_output_hiz_control |-> p4_pad_oe_n[6])
		else $error("hiz pin driven");
	AST_TIMER_B_EXTERNAL_CLOCK_INPUT: assert property (timer_b_external_clock |-> p4_pad_oe_n[7])
		else $error("timer clock pin driven");
	AST_SER_DIR: assert property (serial_in[0] |-> p3_pad_oe_n[0] == !$past(serial_oe[0]))
		else $error("serial direction not followed");
	AST_SER_OUT: assert property (serial_in[0] && !p3_pad_oe_n[0] |-> p3_pad_out[0] == $past(serial_out[0]))
		else $error("serial drive not followed");
	AST_I2C_LOW: assert property (serial_in[1] && $past(serial_i2c_mode) |-> !p3_pad_out[1])
		else $error("i2c pad driven high");
	cover property (capture_input_0a);
	cover property (serial_in[1] && serial_i2c_mode);
	cover property (serial_in[0] && !p3_pad_oe_n[0]);
endmodule
bind ppfm_port_mux ppfm_port_mux_props ppfm_port_mux_props_i (.pclk, .presetn, .psel, .penable, .pready,
	.p2_pad_oe_n, .crystal_input_en, .p3_pad_out, .p3_pad_oe_n, .p4_pad_oe_n, .serial_out, .serial_oe,
	.serial_i2c_mode, .serial_in, .capture_input_0a, .timer_b_output_hiz_control, .timer_b_external_clock);

// File: ppfm_periph_model.sv
`timescale 1ns/1ps
module ppfm_periph_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic run, // Advance outputs
	input wire logic i2c, // I2C mode request
	output logic [5:0] serial_out, // Serial drive
	output logic [5:0] serial_oe, // Serial direction
	output logic serial_i2c_mode, // I2C flag
	output logic [2:0] timer_b_out, // Timer outputs
	output logic aux_clock // Auxiliary clock
);
	logic [7:0] cnt_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_r <= 8'h00;
		else if (run)
			cnt_r <= cnt_r + 8'h01;
	end
	assign serial_out = cnt_r[7:2];
	assign serial_oe = 6'h3f;
	assign serial_i2c_mode = i2c;
	assign timer_b_out = cnt_r[3:1];
	assign aux_clock = cnt_r[0];
endmodule

// File: testbench.sv
`timescale 1ns/1ps
`include "ppfm_cfg.svh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err, run, i2c, aux_clock, serial_i2c_mode;
	logic crystal_input_en, crystal_output_en, comparator_channel_six_en, comparator_channel_seven_en;
	logic capture_input_0a, capture_input_1a, capture_input_2a, capture_input_0b, capture_input_1b;
	logic timer_b_output_hiz_control, timer_b_external_clock;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] p2_pad_in, p2_pad_out, p2_pad_oe_n;
	logic [7:0] p3_pad_in, p3_pad_out, p3_pad_oe_n, p4_pad_in, p4_pad_out, p4_pad_oe_n;
	logic [5:0] serial_out, serial_oe, serial_in;
	logic [2:0] timer_b_out;
	int n_fail, samples_checked;
	ppfm_port_mux ppfm_port_mux_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .p2_pad_in, .p2_pad_out, .p2_pad_oe_n, .p3_pad_in, .p3_pad_out, .p3_pad_oe_n, .p4_pad_in,
		.p4_pad_out, .p4_pad_oe_n, .crystal_input_en, .crystal_output_en, .comparator_channel_six_en,
		.comparator_channel_seven_en, .serial_out, .serial_oe, .serial_i2c_mode, .serial_in, .timer_b_out,
		.aux_clock, .capture_input_0a, .capture_input_1a, .capture_input_2a, .capture_input_0b,
		.capture_input_1b, .timer_b_output_hiz_control, .timer_b_external_clock);
	ppfm_periph_model ppfm_periph_model_i (.pclk, .presetn, .run, .i2c, .serial_out, .serial_oe,
		.serial_i2c_mode, .timer_b_out, .aux_clock);
	task end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	logic [31:0] prdata_q;
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hang
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		prdata_q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(prdata_q, e);
	endtask
	task settle();
		repeat (4) @(posedge pclk);
		@(negedge pclk);
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial
	begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		end_of_test();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, run, i2c} = '0;
		{p2_pad_in, p3_pad_in, p4_pad_in} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		run <= 1'b1;
		rd(`PPFM_ADDR_P2_DIR, 32'h0000_00c0);
		rd(`PPFM_ADDR_P2_SEL, 32'h0000_00c0);
		chk(32'({crystal_input_en, crystal_output_en, p2_pad_oe_n}), 32'h0000_000f);
		rd(8'h40, 32'h0000_0000);
		chk(32'(last_err), 32'h0000_0001);
		apb(1'b1, `PPFM_ADDR_P2_OUT, 32'h0000_0040);
		apb(1'b1, `PPFM_ADDR_P2_SEL, 32'h0000_0000);
		apb(1'b1, `PPFM_ADDR_P2_DIR, 32'h0000_0040);
		p2_pad_in <= 2'b10;
		settle();
		chk(32'({crystal_input_en, crystal_output_en, p2_pad_oe_n, p2_pad_out}), 32'h0000_0009);
		rd(`PPFM_ADDR_P2_IN, 32'h0000_0080);
		apb(1'b1, `PPFM_ADDR_CASEL, 32'h0000_0080);
		rd(`PPFM_ADDR_P2_IN, 32'h0000_0000);
		apb(1'b1, `PPFM_ADDR_CASEL, 32'h0000_0000);
		apb(1'b1, `PPFM_ADDR_ANALOG_PAD_DISABLE, 32'h0000_00c0);
		settle();
		chk(32'({comparator_channel_six_en, comparator_channel_seven_en, p2_pad_oe_n}), 32'h0000_000f);
		rd(`PPFM_ADDR_P2_IN, 32'h0000_0000);
		apb(1'b1, `PPFM_ADDR_P3_DIR, 32'h0000_000f);
		apb(1'b1, `PPFM_ADDR_P3_OUT, 32'h0000_00a5);
		p3_pad_in <= 8'hf0;
		settle();
		chk(32'({p3_pad_oe_n, p3_pad_out}), 32'h0000_f0a5);
		rd(`PPFM_ADDR_P3_IN, 32'h0000_00f0);
		run <= 1'b0;
		p3_pad_in <= 8'hff;
		apb(1'b1, `PPFM_ADDR_P3_SEL, 32'h0000_00ff);
		rd(`PPFM_ADDR_P3_SEL, 32'h0000_003f);
		settle();
		chk(32'({p3_pad_oe_n, p3_pad_out}), 32'({8'hc0, 2'b10, serial_out}));
		chk(32'(serial_in), 32'h0000_003f);
		@(posedge pclk);
		i2c <= 1'b1;
		settle();
		chk(32'({p3_pad_oe_n[2:1], p3_pad_out[2:1]}), 32'({serial_out[2:1], 2'b00}));
		@(posedge pclk);
		p4_pad_in <= 8'hff;
		apb(1'b1, `PPFM_ADDR_P4_SEL, 32'h0000_00ff);
		settle();
		chk(32'({capture_input_0a, capture_input_1a, capture_input_2a, capture_input_0b, capture_input_1b,
			timer_b_output_hiz_control, timer_b_external_clock, p4_pad_oe_n}), 32'h0000_7fff);
		apb(1'b1, `PPFM_ADDR_P4_DIR, 32'h0000_00ff);
		settle();
		chk(32'({p4_pad_oe_n, p4_pad_out[6:0]}), 32'({8'h80, aux_clock, timer_b_out, timer_b_out}));
		chk(32'({capture_input_0a, capture_input_1b, timer_b_output_hiz_control}), 32'h0000_0000);
		apb(1'b1, `PPFM_ADDR_P4_SEL, 32'h0000_0000);
		apb(1'b1, `PPFM_ADDR_P4_OUT, 32'h0000_005a);
		settle();
		chk(32'({p4_pad_oe_n, p4_pad_out}), 32'h0000_005a);
		rd(`PPFM_ADDR_P4_IN, 32'h0000_00ff);
		end_of_test();
	end
endmodule
